// File: src/ipc_regs.svh
`ifndef IPC_REGS_SVH
`define IPC_REGS_SVH
// sub-addresses on the parallel register port
`define IPC_ADDR_BG        8'h80
`define IPC_ADDR_FR1       8'h81
`define IPC_ADDR_FR2       8'h82
`define IPC_ADDR_CMD       8'h83
`define IPC_ADDR_ROLE      8'h84
`define IPC_ADDR_LAYOUT    8'h85
// reset values
`define IPC_RST_BG         16'h0000
`define IPC_RST_FR1        16'h03e0
`define IPC_RST_FR2        16'h501f
`define IPC_RST_ROLE       16'h0000
`define IPC_RST_LAYOUT     16'h0000
`define IPC_RST_CMD        16'h0000
// layout mode number that selects the expert mode
`define IPC_EXPERT_MODE    4'hf
`endif

// File: src/ipc_pkg.sv
package ipc_pkg;
  typedef enum logic [1:0] {
    IPC_MEM_FIRST   = 2'b00,
    IPC_MEM_SECOND  = 2'b01,
    IPC_MEM_RSVD    = 2'b10,
    IPC_MEM_GENERIC = 2'b11
  } ipc_mem_e;
  typedef enum logic [2:0] {
    IPC_CMD_WR_BORD  = 3'b000,
    IPC_CMD_STOP     = 3'b001,
    IPC_CMD_FILL_FR1 = 3'b010,
    IPC_CMD_FILL_FR2 = 3'b011,
    IPC_CMD_FILL_BB  = 3'b100,
    IPC_CMD_FILL_BG  = 3'b101,
    IPC_CMD_WR_PLAIN = 3'b110,
    IPC_CMD_WR_MAIN  = 3'b111
  } ipc_cmd_e;
  typedef struct packed {
    logic [3:0] rsvd;
    logic       write_pointer_reset_invert;
    logic       in_out_enable_invert;
    logic       write_read_strobe_invert;
    logic       output_delay_select;
    ipc_mem_e   field_memory_type;
    logic       short_frame_window_select;
    logic       fast_pixel_rate_select;
    logic       widescreen_select;
    logic       main_role_select;
    logic       one_chip_select;
    logic       field_memory_ctrl_enable;
  } ipc_role_s;
  typedef struct packed {
    logic [1:0] rsvd;
    logic [5:0] upshift_line_count;
    logic       upshift_enable;
    logic       main_background_show;
    logic       dual_buffer_select;
    logic       both_fields_write;
    logic [3:0] layout_mode_number;
  } ipc_layout_s;
  typedef struct packed {
    logic [7:0] rsvd;
    logic       new_command_flag;
    ipc_cmd_e   code;
    logic [1:0] inset_index_y;
    logic [1:0] inset_index_x;
  } ipc_cmd_s;
  typedef struct packed {
    logic [7:0] y;
    logic [7:0] cb;
    logic [7:0] cr;
  } ipc_ycc_s;
endpackage : ipc_pkg

// File: src/ipc_top.sv
//Function
//RULE1 - field memory control only when enable set
//RULE2 - bit1 one/two chip, bit2 source/main
//RULE3 - bit3 screen geometry, bit4 pixel rate
//RULE4 - bit5 selects 625 or 525 window
//RULE5 - two-bit memory type decode, 10 reserved
//RULE6 - bits 11:8 used only for generic memory
//RULE7 - bit8 delays video zero or one cycle
//RULE8 - bits 9..11 invert strobe polarities
//RULE9 - host writes zero to bits 15:12
//RULE10 - new settings take effect on command write
//RULE11 - layout mode number in low four bits
//RULE12 - bit4 writes one or both fields
//RULE13 - bit5 selects one or two buffers
//RULE14 - main role bit6 shows background colour
//RULE15 - main role bit7 up-shift by 13:8 lines
//RULE16 - command bits 1:0 x, 3:2 y index
//RULE17 - codes 000, 001, 110 write control
//RULE18 - codes 010..101 fill operations
//RULE19 - code 111 only in one-chip role
//RULE20 - main role accepts only 000
//RULE21 - device clears new-command flag when done
//RULE22 - frame colour expands to 8-bit components
//RULE23 - apply latched settings at field boundary
`timescale 1ns/1ps
`default_nettype none
`include "ipc_regs.svh"
module ipc_top (
  input  wire logic              mclk_i,
  input  wire logic              srst_i,
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic [15:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [15:0]       reg_rdata_o,
  output logic                   reg_rvalid_o,
  input  wire logic              field_start_i,
  input  wire logic              wr_rd_strobe_i,
  input  wire logic              in_out_enable_i,
  input  wire logic              wp_reset_i,
  input  wire logic [15:0]       video_i,
  output logic      [15:0]       video_o,
  output logic                   memory_write_strobe_o,
  output logic                   memory_read_strobe_o,
  output logic                   memory_input_enable_o,
  output logic                   memory_output_enable_o,
  output logic                   write_pointer_reset_o,
  output ipc_pkg::ipc_role_s     role_o,
  output logic                   expert_mode_o,
  output ipc_pkg::ipc_layout_s   layout_o,
  output ipc_pkg::ipc_ycc_s      bg_colour_o,
  output ipc_pkg::ipc_ycc_s      frame_one_o,
  output ipc_pkg::ipc_ycc_s      frame_two_o,
  output logic                   cmd_pulse_o,
  output ipc_pkg::ipc_cmd_e      cmd_code_o,
  output logic      [1:0]        inset_index_x_o,
  output logic      [1:0]        inset_index_y_o,
  output logic                   cmd_reject_o
);

  // ----------------------------------------------------------------
  // host-visible registers
  // ----------------------------------------------------------------
  logic [15:0]         bg_reg;
  logic [15:0]         fr1_reg;
  logic [15:0]         fr2_reg;
  ipc_pkg::ipc_role_s   role_reg;
  ipc_pkg::ipc_layout_s layout_reg;
  ipc_pkg::ipc_cmd_s    cmd_reg;
  logic                wr_bg;
  logic                wr_fr1;
  logic                wr_fr2;
  logic                wr_role;
  logic                wr_layout;
  logic                wr_cmd;
  logic                cmd_new;
  logic                pend_reg;
  logic                apply;

  assign wr_bg     = reg_wr_i && (reg_addr_i == `IPC_ADDR_BG);
  assign wr_fr1    = reg_wr_i && (reg_addr_i == `IPC_ADDR_FR1);
  assign wr_fr2    = reg_wr_i && (reg_addr_i == `IPC_ADDR_FR2);
  assign wr_role   = reg_wr_i && (reg_addr_i == `IPC_ADDR_ROLE);
  assign wr_layout = reg_wr_i && (reg_addr_i == `IPC_ADDR_LAYOUT);
  assign wr_cmd    = reg_wr_i && (reg_addr_i == `IPC_ADDR_CMD);
  assign cmd_new   = wr_cmd && reg_wdata_i[7];
  // a command written in the apply cycle stays pending
  assign apply     = pend_reg && field_start_i && !cmd_new;

  // reserved bits are stored as written; the host keeps them zero [RULE9]
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      bg_reg     <= `IPC_RST_BG;
      fr1_reg    <= `IPC_RST_FR1;
      fr2_reg    <= `IPC_RST_FR2;
      role_reg   <= `IPC_RST_ROLE;
      layout_reg <= `IPC_RST_LAYOUT;
    end else begin
      if (wr_bg)     bg_reg     <= reg_wdata_i;
      if (wr_fr1)    fr1_reg    <= reg_wdata_i;
      if (wr_fr2)    fr2_reg    <= reg_wdata_i;
      if (wr_role)   role_reg   <= reg_wdata_i;
      if (wr_layout) layout_reg <= reg_wdata_i;
    end
  end

  // the flag is set by the host and cleared on completion; set wins
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cmd_reg <= `IPC_RST_CMD;
    end else if (wr_cmd) begin
      cmd_reg <= reg_wdata_i;
    end else if (apply) begin
      cmd_reg.new_command_flag <= 1'b0; // [RULE21]
    end
  end

  // ----------------------------------------------------------------
  // latch on command write, apply at the next field start
  // ----------------------------------------------------------------
  logic [15:0]         lat_bg;
  logic [15:0]         lat_fr1;
  logic [15:0]         lat_fr2;
  ipc_pkg::ipc_role_s   lat_role;
  ipc_pkg::ipc_layout_s lat_layout;
  ipc_pkg::ipc_cmd_s    lat_cmd;

  // new values have no effect until the command register is written
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      lat_bg     <= `IPC_RST_BG;
      lat_fr1    <= `IPC_RST_FR1;
      lat_fr2    <= `IPC_RST_FR2;
      lat_role   <= `IPC_RST_ROLE;
      lat_layout <= `IPC_RST_LAYOUT;
      lat_cmd    <= `IPC_RST_CMD;
    end else if (cmd_new) begin
      lat_bg     <= bg_reg; // [RULE10]
      lat_fr1    <= fr1_reg;
      lat_fr2    <= fr2_reg;
      lat_role   <= role_reg;
      lat_layout <= layout_reg;
      lat_cmd    <= reg_wdata_i;
    end
  end

  // switching mid-field would tear the picture between old and new settings
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pend_reg <= 1'b0;
    end else if (cmd_new) begin
      pend_reg <= 1'b1;
    end else if (apply) begin
      pend_reg <= 1'b0; // [RULE23]
    end
  end

  // ----------------------------------------------------------------
  // active settings
  // ----------------------------------------------------------------
  ipc_pkg::ipc_role_s   act_role;
  ipc_pkg::ipc_layout_s act_layout;
  logic                generic;
  logic                expert;

  assign generic = (lat_role.field_memory_type == ipc_pkg::IPC_MEM_GENERIC);
  assign expert  = (lat_layout.layout_mode_number == `IPC_EXPERT_MODE);

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      act_role <= `IPC_RST_ROLE;
    end else if (apply) begin
      act_role                           <= lat_role; // [RULE2] [RULE3] [RULE4] [RULE5]
      act_role.rsvd                      <= 4'h0;
      // delay and polarity bits only count for the generic memory
      act_role.output_delay_select        <= generic && lat_role.output_delay_select; // [RULE6]
      act_role.write_read_strobe_invert   <= generic && lat_role.write_read_strobe_invert;
      act_role.in_out_enable_invert       <= generic && lat_role.in_out_enable_invert;
      act_role.write_pointer_reset_invert <= generic && lat_role.write_pointer_reset_invert;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      act_layout    <= `IPC_RST_LAYOUT;
      expert_mode_o <= 1'b0;
    end else if (apply) begin
      act_layout.rsvd               <= 2'h0;
      act_layout.layout_mode_number <= lat_layout.layout_mode_number; // [RULE11]
      act_layout.both_fields_write  <= expert && !lat_layout.dual_buffer_select
                                       && lat_layout.both_fields_write; // [RULE12]
      act_layout.dual_buffer_select <= expert && lat_layout.dual_buffer_select; // [RULE13]
      act_layout.main_background_show <= expert && lat_role.main_role_select
                                         && lat_layout.main_background_show; // [RULE14]
      act_layout.upshift_enable     <= lat_role.main_role_select
                                       && lat_layout.upshift_enable; // [RULE15]
      act_layout.upshift_line_count <= (lat_role.main_role_select && lat_layout.upshift_enable)
                                       ? lat_layout.upshift_line_count : 6'h00;
      expert_mode_o                 <= expert;
    end
  end

  assign role_o   = act_role;
  assign layout_o = act_layout;

  // ----------------------------------------------------------------
  // colours
  // ----------------------------------------------------------------
  function automatic ipc_pkg::ipc_ycc_s ipc_expand(input logic [15:0] c);
    ipc_pkg::ipc_ycc_s r;
    r.cr = {c[4:0], 3'h0};
    r.cb = {c[9:5], 3'h0};
    r.y  = {c[15:10], 2'h0};
    return r;
  endfunction : ipc_expand

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      bg_colour_o <= ipc_expand(`IPC_RST_BG);
      frame_one_o <= ipc_expand(`IPC_RST_FR1);
      frame_two_o <= ipc_expand(`IPC_RST_FR2);
    end else if (apply) begin
      bg_colour_o <= ipc_expand(lat_bg); // [RULE22]
      frame_one_o <= ipc_expand(lat_fr1);
      frame_two_o <= ipc_expand(lat_fr2);
    end
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic cmd_ok;

  always_comb begin
    cmd_ok = 1'b0;
    if (lat_role.main_role_select) begin
      cmd_ok = (lat_cmd.code == ipc_pkg::IPC_CMD_WR_BORD); // [RULE20]
    end else begin
      unique case (lat_cmd.code)
        ipc_pkg::IPC_CMD_WR_BORD,
        ipc_pkg::IPC_CMD_STOP,
        ipc_pkg::IPC_CMD_WR_PLAIN:  cmd_ok = 1'b1; // [RULE17]
        ipc_pkg::IPC_CMD_FILL_FR1,
        ipc_pkg::IPC_CMD_FILL_FR2,
        ipc_pkg::IPC_CMD_FILL_BB,
        ipc_pkg::IPC_CMD_FILL_BG:   cmd_ok = 1'b1; // [RULE18]
        ipc_pkg::IPC_CMD_WR_MAIN:   cmd_ok = lat_role.one_chip_select; // [RULE19]
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cmd_pulse_o     <= 1'b0;
      cmd_reject_o    <= 1'b0;
      cmd_code_o      <= ipc_pkg::IPC_CMD_WR_BORD;
      inset_index_x_o <= 2'h0;
      inset_index_y_o <= 2'h0;
    end else begin
      cmd_pulse_o  <= apply && cmd_ok;
      cmd_reject_o <= apply && !cmd_ok;
      if (apply && cmd_ok) begin
        cmd_code_o <= lat_cmd.code;
        // index bits are reserved in the main role
        inset_index_x_o <= lat_role.main_role_select ? 2'h0 : lat_cmd.inset_index_x; // [RULE16]
        inset_index_y_o <= lat_role.main_role_select ? 2'h0 : lat_cmd.inset_index_y;
      end
    end
  end

  // ----------------------------------------------------------------
  // field memory pins and video delay
  // ----------------------------------------------------------------
  logic [15:0] video_d;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      memory_write_strobe_o  <= 1'b0;
      memory_read_strobe_o   <= 1'b0;
      memory_input_enable_o  <= 1'b0;
      memory_output_enable_o <= 1'b0;
      write_pointer_reset_o  <= 1'b0;
    end else begin
      // disabled control still holds the inactive level of its polarity
      memory_write_strobe_o  <= (act_role.field_memory_ctrl_enable && wr_rd_strobe_i)
                                ^ act_role.write_read_strobe_invert; // [RULE1] [RULE8]
      memory_read_strobe_o   <= (act_role.field_memory_ctrl_enable && wr_rd_strobe_i)
                                ^ act_role.write_read_strobe_invert;
      memory_input_enable_o  <= (act_role.field_memory_ctrl_enable && in_out_enable_i)
                                ^ act_role.in_out_enable_invert;
      memory_output_enable_o <= (act_role.field_memory_ctrl_enable && in_out_enable_i)
                                ^ act_role.in_out_enable_invert;
      write_pointer_reset_o  <= (act_role.field_memory_ctrl_enable && wp_reset_i)
                                ^ act_role.write_pointer_reset_invert;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      video_d <= 16'h0000;
      video_o <= 16'h0000;
    end else begin
      video_d <= video_i;
      video_o <= act_role.output_delay_select ? video_d : video_i; // [RULE7]
    end
  end

  // ----------------------------------------------------------------
  // register read-back
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      reg_rdata_o  <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          `IPC_ADDR_BG:     reg_rdata_o <= bg_reg;
          `IPC_ADDR_FR1:    reg_rdata_o <= fr1_reg;
          `IPC_ADDR_FR2:    reg_rdata_o <= fr2_reg;
          `IPC_ADDR_CMD:    reg_rdata_o <= cmd_reg;
          `IPC_ADDR_ROLE:   reg_rdata_o <= role_reg;
          `IPC_ADDR_LAYOUT: reg_rdata_o <= layout_reg;
          default:          reg_rdata_o <= 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  flag_clear_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE21]
    apply |=> !cmd_reg.new_command_flag)
    else $error("flag not cleared on apply");
  held_value_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE10]
    !apply |=> $stable(act_role))
    else $error("role changed without apply");
  field_apply_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE23]
    !field_start_i |=> $stable(act_role) && $stable(act_layout))
    else $error("settings changed outside field start");
  generic_gate_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE6]
    apply && !generic |=> act_role[11:8] == 4'h0)
    else $error("polarity bits used for non-generic memory");
  mem_disable_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE1]
    !act_role.field_memory_ctrl_enable |=>
      memory_write_strobe_o == $past(act_role.write_read_strobe_invert))
    else $error("memory strobe active while disabled");
  video_delay_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE7]
    act_role.output_delay_select ##1 act_role.output_delay_select
      |-> video_o == $past(video_i, 2))
    else $error("video delay wrong");
  main_only_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE20]
    apply && lat_role.main_role_select && lat_cmd.code != ipc_pkg::IPC_CMD_WR_BORD
      |=> cmd_reject_o && !cmd_pulse_o)
    else $error("main role accepted reserved code");
  single_main_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE19]
    apply && !lat_role.main_role_select && !lat_role.one_chip_select
      && lat_cmd.code == ipc_pkg::IPC_CMD_WR_MAIN |=> cmd_reject_o)
    else $error("main write accepted without one-chip role");
  colour_map_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE22]
    apply |=> frame_one_o.y == {$past(lat_fr1[15:10]), 2'h0})
    else $error("frame colour expansion wrong");
  flag_set_wins_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE21]
    cmd_new |=> cmd_reg.new_command_flag)
    else $error("new command flag lost");
  pend_hold_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE23]
    cmd_new |=> pend_reg)
    else $error("new command not pending");
  main_index_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE20]
    cmd_pulse_o && role_o.main_role_select
      |-> inset_index_x_o == 2'h0 && inset_index_y_o == 2'h0)
    else $error("index used in main role");

endmodule : ipc_top
`default_nettype wire

// File: test/ipc_fmem_model.sv
`timescale 1ns/1ps
`default_nettype none
// field memory stand-in on the read side
module ipc_fmem_model (
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  output logic      [15:0] video_o = 16'h0000
);
  // read data changes every cycle, so a missing or doubled video stage shows up
  always @(negedge mclk_i) begin
    if (srst_i) begin
      video_o <= 16'h0000;
    end else begin
      video_o <= video_o + 16'h0001;
    end
  end
endmodule : ipc_fmem_model
`default_nettype wire

// File: test/test_inset_picture_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "ipc_regs.svh"
module test_inset_picture_control_regs;
  logic                 mclk_i = 1'b0;
  logic                 srst_i = 1'b1;
  logic [7:0]           addr   = 8'h00;
  logic [15:0]          wdata  = 16'h0000;
  logic                 wr = 1'b0, rd = 1'b0, fs = 1'b0;
  logic                 wrs = 1'b0, ioe = 1'b0, wpr = 1'b0;
  logic [15:0]          rdata, vid_in, vid_out;
  logic                 rvalid, mws, mrs, mie, moe, wpo, expert, pulse, reject;
  ipc_pkg::ipc_role_s   role;
  ipc_pkg::ipc_layout_s layout;
  ipc_pkg::ipc_ycc_s    bg, fr1, fr2;
  ipc_pkg::ipc_cmd_e    code;
  logic [1:0]           ix, iy;
  int                   err_count = 0, cmp_count = 0, cycles = 0;
  logic [7:0]  raddr [7] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h90};
  logic [15:0] rrst  [7] = '{`IPC_RST_BG, `IPC_RST_FR1, `IPC_RST_FR2, `IPC_RST_CMD,
                             `IPC_RST_ROLE, `IPC_RST_LAYOUT, 16'h0000};

  ipc_top ipc_top_inst (
    .mclk_i(mclk_i), .srst_i(srst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .field_start_i(fs), .wr_rd_strobe_i(wrs), .in_out_enable_i(ioe), .wp_reset_i(wpr),
    .video_i(vid_in), .video_o(vid_out), .memory_write_strobe_o(mws),
    .memory_read_strobe_o(mrs), .memory_input_enable_o(mie), .memory_output_enable_o(moe),
    .write_pointer_reset_o(wpo), .role_o(role), .expert_mode_o(expert), .layout_o(layout),
    .bg_colour_o(bg), .frame_one_o(fr1), .frame_two_o(fr2), .cmd_pulse_o(pulse),
    .cmd_code_o(code), .inset_index_x_o(ix), .inset_index_y_o(iy), .cmd_reject_o(reject)
  );
  ipc_fmem_model ipc_fmem_model_inst (.mclk_i(mclk_i), .srst_i(srst_i), .video_o(vid_in));

  always #5 mclk_i = ~mclk_i;

  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(negedge mclk_i);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge mclk_i);
    wr = 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp, input string what);
    @(negedge mclk_i);
    addr = a;
    rd = 1'b1;
    @(negedge mclk_i);
    rd = 1'b0;
    chk("read valid", 24'h000001, {23'h0, rvalid});
    chk(what, {8'h00, exp}, {8'h00, rdata});
  endtask : rd_reg

  // field boundary, then wait a bounded time for the apply pulse
  task automatic fire;
    int n;
    @(negedge mclk_i);
    fs = 1'b1;
    @(negedge mclk_i);
    fs = 1'b0;
    n = 0;
    while (pulse !== 1'b1 && reject !== 1'b1 && n < 4) begin
      @(negedge mclk_i);
      n++;
    end
  endtask : fire

  task automatic apply(input logic [15:0] r, input logic [15:0] l, input logic [15:0] c);
    wr_reg(`IPC_ADDR_ROLE, r);
    wr_reg(`IPC_ADDR_LAYOUT, l);
    wr_reg(`IPC_ADDR_CMD, c);
    fire();
  endtask : apply

  task automatic acc(input logic ok);
    chk("accept and reject", ok ? 24'h000002 : 24'h000001, {22'h0, pulse, reject});
  endtask : acc

  task automatic mem(input logic [2:0] req, input logic [4:0] exp);
    @(negedge mclk_i);
    {wrs, ioe, wpr} = req;
    @(negedge mclk_i);
    chk("memory pins", {19'h0, exp}, {19'h0, mws, mrs, mie, moe, wpo});
  endtask : mem

  // model data advances at falling edges, so one stage of latency reads equal here
  task automatic vid(input logic [15:0] extra);
    @(negedge mclk_i);
    chk("video out", {8'h00, vid_in - extra}, {8'h00, vid_out});
  endtask : vid

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
    srst_i = 1'b0;
    for (int i = 0; i < 7; i++) rd_reg(raddr[i], rrst[i], "reset value");
    chk("frame one colour", 24'h00f800, fr1);
    chk("frame two colour", 24'h5000f8, fr2);
    $display("test reset values done");

    wr_reg(`IPC_ADDR_BG, 16'h8421);
    wr_reg(`IPC_ADDR_FR1, 16'hfc1f);
    wr_reg(`IPC_ADDR_ROLE, 16'h0fc1);
    wr_reg(`IPC_ADDR_CMD, 16'h0095);
    repeat (3) @(negedge mclk_i);
    chk("bg before apply", 24'h000000, bg);
    chk("role before apply", 24'h000000, {8'h00, role});
    rd_reg(`IPC_ADDR_CMD, 16'h0095, "flag pending");
    fire();
    acc(1'b1);
    chk("bg colour", 24'h840808, bg);
    chk("frame one new", 24'hfc00f8, fr1);
    chk("role applied", 24'h000fc1, {8'h00, role});
    chk("index", 24'h000005, {20'h0, iy, ix});
    rd_reg(`IPC_ADDR_CMD, 16'h0015, "flag cleared");
    $display("test latch and apply done");

    mem(3'b101, 5'b00110);
    vid(16'h0001);
    apply(16'h00c1, 16'h0000, 16'h0080);
    mem(3'b101, 5'b11001);
    vid(16'h0000);
    apply(16'h0fc0, 16'h0000, 16'h0080);
    mem(3'b111, 5'b11111);
    mem(3'b000, 5'b11111);
    apply(16'h0f01, 16'h0000, 16'h0080);
    chk("role type first", 24'h000001, {8'h00, role});
    mem(3'b101, 5'b11001);
    vid(16'h0000);
    apply(16'h0f81, 16'h0000, 16'h0080);
    chk("role type reserved", 24'h000081, {8'h00, role});
    apply(16'h007f, 16'h0000, 16'h0080);
    chk("role fields", 24'h00007f, {8'h00, role});
    $display("test memory pins done");

    for (int c = 0; c < 8; c++) begin
      apply(16'h0001, 16'h0000, {9'h001, c[2:0], 4'h9});
      acc(c != 7);
      if (c != 7) chk("command code", {21'h0, c[2:0]}, {21'h0, code});
      if (c != 7) chk("index", 24'h000009, {20'h0, iy, ix});
    end
    apply(16'h0003, 16'h0000, 16'h00f0);
    acc(1'b1);
    apply(16'h0005, 16'h0000, 16'h0085);
    acc(1'b1);
    chk("main index", 24'h000000, {20'h0, iy, ix});
    apply(16'h0005, 16'h0000, 16'h00b0);
    acc(1'b0);
    $display("test command codes done");

    apply(16'h0005, 16'h05ff, 16'h0080);
    chk("layout main", 24'h0005ef, {8'h00, layout});
    chk("expert", 24'h000001, {23'h0, expert});
    apply(16'h0001, 16'h05ff, 16'h0080);
    chk("layout source", 24'h00002f, {8'h00, layout});
    apply(16'h0001, 16'h001f, 16'h0080);
    chk("layout both fields", 24'h00001f, {8'h00, layout});
    apply(16'h0001, 16'h0013, 16'h0080);
    chk("layout plain", 24'h000003, {8'h00, layout});
    chk("expert off", 24'h000000, {23'h0, expert});
    $display("test layout done");

    // a command written in the field start cycle must hold off the apply
    wr_reg(`IPC_ADDR_CMD, 16'h0080);
    @(negedge mclk_i);
    fs = 1'b1;
    addr = `IPC_ADDR_CMD;
    wdata = 16'h00b0;
    wr = 1'b1;
    @(negedge mclk_i);
    fs = 1'b0;
    wr = 1'b0;
    chk("no early pulse", 24'h000000, {22'h0, pulse, reject});
    rd_reg(`IPC_ADDR_CMD, 16'h00b0, "flag kept");
    fire();
    acc(1'b1);
    chk("second command wins", 24'h000003, {21'h0, code});
    $display("test command overlap done");
    give_verdict();
  end
endmodule : test_inset_picture_control_regs
`default_nettype wire
